// ==== pvt_params.svh ====
`ifndef PVT_PARAMS_SVH
`define PVT_PARAMS_SVH
// Level counter width and reset codes
`define PVT_LVL_W 8
`define PVT_PEAK_RST 8'h80
`define PVT_VALLEY_RST 8'h80
// Step sizes in counts
`define PVT_SLOW_ATTACK 8'h02
`define PVT_FAST_ATTACK 8'h04
`define PVT_FAST_DECAY 8'h08
`define PVT_ONE_STEP 8'h01
// Slow decay interval in clocks
`define PVT_DECAY_DIV 6'h28
`define PVT_DECAY_ONE 6'h01
`endif

// ==== pvt_pkg.sv ====
package pvt_pkg;
  // Operating modes picked by the mode pins
  typedef enum logic [1:0] {
    PVT_MODE_OFF = 2'h0,
    PVT_MODE_FAST = 2'h1,
    PVT_MODE_HOLD = 2'h2,
    PVT_MODE_SLOW = 2'h3
  } pvt_mode_t;
  // Test configurations, Gray along 0-1-3-2
  typedef enum logic [1:0] {
    PVT_TCFG0 = 2'h0,
    PVT_TCFG1 = 2'h1,
    PVT_TCFG3 = 2'h3,
    PVT_TCFG2 = 2'h2
  } pvt_tcfg_t;
endpackage

// ==== pvt_level_ctr.sv ====
`timescale 1ns/10ps
`include "pvt_params.svh"
// One level counter with its decay-rate counter
module pvt_level_ctr
  import pvt_pkg::*;
#(
  parameter int W = `PVT_LVL_W,
  parameter logic [W-1:0] RST_VAL = `PVT_PEAK_RST
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clr, // Synchronous logic reset
  input wire logic en, // Counter may move
  input wire logic fast, // Fast stepping
  input wire logic attack, // Attack enable
  input wire logic decay, // Decay enable
  input wire logic up_attack, // Attack direction is upward
  output logic [W-1:0] level, // Level code
  output logic decay_tick // Decay counter output
);
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;
  logic [5:0] dcnt_reg;
  logic [5:0] dcnt_next;
  logic [W-1:0] step; // Magnitude of this clock's step
  logic go_up; // Direction of this clock's step
  logic move;
  logic slow_dec_due;

  // Saturating add or subtract
  function automatic logic [W-1:0] sat_step(input logic [W-1:0] v, input logic [W-1:0] s,
                                            input logic up);
    logic [W:0] t;
    t = '0;
    if (up) begin
      t = {1'b0, v} + {1'b0, s};
      sat_step = t[W] ? '1 : t[W-1:0];
    end else begin
      sat_step = (v < s) ? '0 : v - s;
    end
  endfunction

  assign slow_dec_due = (dcnt_reg == `PVT_DECAY_ONE);
  // Attack wins over decay
  assign step = attack ? (fast ? `PVT_FAST_ATTACK : `PVT_SLOW_ATTACK)
              : (fast ? `PVT_FAST_DECAY : `PVT_ONE_STEP);
  assign go_up = attack ? up_attack : ~up_attack;
  assign move = en & (attack | (decay & (fast | slow_dec_due)));
  assign level_next = move ? sat_step(level_reg, step, go_up) : level_reg;
  // Decay counter: reload 1 after attack / in fast, 40 after a decay step
  assign dcnt_next = (!en || fast || attack) ? `PVT_DECAY_ONE
                   : (decay ? (slow_dec_due ? `PVT_DECAY_DIV : dcnt_reg - 6'h01) : dcnt_reg);

  // ****************************
  // Registers
  // ****************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clr) begin
      level_reg <= RST_VAL;
      dcnt_reg <= `PVT_DECAY_ONE;
    end else begin
      level_reg <= level_next;
      dcnt_reg <= dcnt_next;
    end
  end

  assign level = level_reg;
  assign decay_tick = slow_dec_due;

  // Slow attack moves by exactly two
  a_slow_attack_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (en && attack && !fast && !clr && up_attack && level_reg < 8'hfd)
    |=> (level_reg == $past(level_reg) + 8'h02))
    else $error("slow attack step wrong");
  // Fast decay moves by eight
  a_fast_decay_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (en && decay && !attack && fast && !clr && !up_attack && level_reg < 8'hf7)
    |=> (level_reg == $past(level_reg) + 8'h08))
    else $error("fast decay step wrong");
  // Disabled counter holds
  a_hold_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!en && !clr) |=> $stable(level_reg))
    else $error("disabled counter moved");
endmodule

// ==== pvt_top.sv ====
`timescale 1ns/10ps
`include "pvt_params.svh"
// ****************************
// Summary of operation
// - Test high: mode pins pick configuration 0-3
// - Config 0 enables and clocks all counters
// - Config 0: bandwidth select high resets counters
// - Config 0: hold pin sets direction, decay output
// - Config 0: peak to upper, valley to lower
// - From slow track: bias picks both rates
// - From fast track: valley rate inverted
// - Config 1: bandwidth picks cutoff, filter upper
// - Config 1: counters and converter disabled
// - Config 2: level counters frozen as hold
// - Config 2: peak compare lower, valley upper
// - Config 3: pins disable peak/valley separately
// - Config 3: filter forced to 1 kHz
// - Config 3: normal 2-bit result out
// - Slow: attack 2 each clock, decay per 40
// - Fast: attack 4, decay 8, decay counter 1
// - Level counters are 8-bit up/down
// ****************************
module pvt_top
  import pvt_pkg::*;
#(
  parameter int W = `PVT_LVL_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic test_en, // Test pin, async
  input wire logic mode_sel_hi, // Mode pin one
  input wire logic mode_sel_lo, // Mode pin two
  input wire logic bandwidth_select, // Filter / test control pin
  input wire logic tracking_hold_ctrl, // Tracking hold pin
  input wire logic bias_level_in, // Bias level comparator as digital level
  input wire logic peak_cmp_in, // Peak comparator: signal above peak
  input wire logic valley_cmp_in, // Valley comparator: signal below valley
  input wire logic [1:0] adc_code_in, // Raw 2-bit converter code
  input wire logic filter_cmp_in, // Filter output as a logic level
  output logic level_out_msb, // Upper level output pin
  output logic level_out_lsb, // Lower level output pin
  output logic sig_out, // Signal pin driven in test config 0
  output logic [W-1:0] peak_level, // Peak counter code to DAC
  output logic [W-1:0] valley_level, // Valley counter code to DAC
  output logic filter_wide, // High selects 2 kHz cutoff
  output logic adc_enable, // Converter on
  output logic upper_is_analog, // Upper pin carries filter output
  output logic [1:0] test_cfg // Active configuration, 0 outside test
);
  // ****************************
  // Pin synchronisers
  // ****************************
  logic [8:0] s1_reg; // First stage, read only by s2
  logic [8:0] s2_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= {test_en, mode_sel_hi, mode_sel_lo, bandwidth_select, tracking_hold_ctrl,
                 bias_level_in, peak_cmp_in, valley_cmp_in, filter_cmp_in};
      s2_reg <= s1_reg;
    end
  end
  wire t_on = s2_reg[8];
  wire [1:0] msel = s2_reg[7:6];
  wire bw_s = s2_reg[5];
  wire th_s = s2_reg[4];
  wire bias_s = s2_reg[3];
  wire pk_s = s2_reg[2];
  wire vl_s = s2_reg[1];
  wire flt_s = s2_reg[0];
  logic [1:0] adc1_reg;
  logic [1:0] adc2_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      adc1_reg <= '0;
      adc2_reg <= '0;
    end else begin
      adc1_reg <= adc_code_in;
      adc2_reg <= adc1_reg;
    end
  end

  // ****************************
  // Mode decode
  // ****************************
  pvt_tcfg_t cfg; // Test configuration from mode pins
  assign cfg = pvt_tcfg_t'(msel);
  wire in_t0 = t_on && cfg == PVT_TCFG0;
  wire in_t1 = t_on && cfg == PVT_TCFG1;
  wire in_t2 = t_on && cfg == PVT_TCFG2;
  wire in_t3 = t_on && cfg == PVT_TCFG3;
  pvt_mode_t nmode; // Normal operating mode
  assign nmode = pvt_mode_t'(msel);

  // Last tracking mode seen before entering test, remembered
  logic was_fast_reg;
  logic was_fast_next;
  assign was_fast_next = (!t_on && nmode == PVT_MODE_FAST) ? 1'b1
                       : (!t_on && nmode == PVT_MODE_SLOW) ? 1'b0 : was_fast_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      was_fast_reg <= 1'b0;
    end else begin
      was_fast_reg <= was_fast_next;
    end
  end

  // ****************************
  // Counter controls
  // ****************************
  wire clr = in_t0 & bw_s;
  // Normal operation: slow/fast track with tracking enabled
  wire norm_en = !t_on && !th_s && (nmode == PVT_MODE_FAST || nmode == PVT_MODE_SLOW);
  wire t3_pk_en = in_t3 & ~bw_s;
  wire t3_vl_en = in_t3 & ~th_s;
  wire pk_en = norm_en | in_t0 | t3_pk_en;
  wire vl_en = norm_en | in_t0 | t3_vl_en;
  // Rates: test 0 from bias pin, else last tracking mode
  wire pk_fast = in_t0 ? bias_s : (t_on ? was_fast_reg : nmode == PVT_MODE_FAST);
  wire vl_fast = in_t0 ? (bias_s ^ was_fast_reg) : pk_fast;
  // Test 0 runs both counters on the decay path, so the decay counters see use
  wire pk_att = in_t0 ? 1'b0 : pk_s;
  wire pk_dec = in_t0 ? 1'b1 : ~pk_s;
  wire vl_att = in_t0 ? 1'b0 : vl_s;
  wire vl_dec = in_t0 ? 1'b1 : ~vl_s;
  // Decay moves against the attack direction: hold pin high means count up
  wire pk_up = in_t0 ? ~th_s : 1'b1;
  wire vl_up = in_t0 ? ~th_s : 1'b0;
  logic pk_tick;
  logic vl_tick;
  logic [W-1:0] peak_level_w; // Peak counter code
  logic [W-1:0] valley_level_w; // Valley counter code

  pvt_level_ctr #(.W(W), .RST_VAL(`PVT_PEAK_RST)) u_peak (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clr(clr),
    .en(pk_en),
    .fast(pk_fast),
    .attack(pk_att),
    .decay(pk_dec),
    .up_attack(pk_up),
    .level(peak_level_w),
    .decay_tick(pk_tick)
  );
  pvt_level_ctr #(.W(W), .RST_VAL(`PVT_VALLEY_RST)) u_valley (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clr(clr),
    .en(vl_en),
    .fast(vl_fast),
    .attack(vl_att),
    .decay(vl_dec),
    .up_attack(vl_up),
    .level(valley_level_w),
    .decay_tick(vl_tick)
  );

  // ****************************
  // Output routing
  // ****************************
  // Test 0 uses counter MSBs as DAC level stand-ins
  wire msb_next = in_t0 ? peak_level_w[W-1]
                : in_t1 ? flt_s
                : in_t2 ? vl_s
                : adc2_reg[1];
  wire lsb_next = in_t0 ? valley_level_w[W-1]
                : in_t1 ? 1'b0
                : in_t2 ? pk_s
                : adc2_reg[0];
  wire sig_next = in_t0 & (th_s ? pk_tick : vl_tick);
  wire wide_next = in_t3 ? 1'b0 : bw_s;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      level_out_msb <= 1'b0;
      level_out_lsb <= 1'b0;
      sig_out <= 1'b0;
      peak_level <= `PVT_PEAK_RST;
      valley_level <= `PVT_VALLEY_RST;
      filter_wide <= 1'b0;
      adc_enable <= 1'b0;
      upper_is_analog <= 1'b0;
      test_cfg <= 2'h0;
    end else begin
      level_out_msb <= msb_next;
      level_out_lsb <= lsb_next;
      sig_out <= sig_next;
      peak_level <= peak_level_w;
      valley_level <= valley_level_w;
      filter_wide <= wide_next;
      adc_enable <= ~in_t1;
      upper_is_analog <= in_t1;
      test_cfg <= t_on ? msel : 2'h0;
    end
  end

  // Config 3 always picks 1 kHz
  a_t3_narrow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    in_t3 |=> !filter_wide)
    else $error("filter not forced narrow");
  // Config 1 turns converter off, routes filter
  a_t1_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    in_t1 |=> (!adc_enable && upper_is_analog && level_out_msb == $past(flt_s)))
    else $error("config 1 routing wrong");
  // Config 2 swaps comparators onto pins
  a_t2_swap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    in_t2 |=> (level_out_lsb == $past(pk_s) && level_out_msb == $past(vl_s)))
    else $error("config 2 routing wrong");
  // Logic reset in config 0 clears counter
  a_t0_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clr |=> ##1 (peak_level == `PVT_PEAK_RST))
    else $error("config 0 reset ignored");
  // Config 3 disable freezes peak
  a_t3_pk_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (in_t3 && bw_s) |=> $stable(peak_level_w))
    else $error("peak moved while disabled");
  // Decode of mode pins
  a_cfg_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    t_on |=> test_cfg == $past(msel))
    else $error("configuration decode wrong");
  // Signal pin mux
  a_sig_mux: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (in_t0 && th_s) |=> sig_out == $past(pk_tick))
    else $error("signal pin mux wrong");
  // Valley rate inversion from fast track
  a_vl_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (in_t0 && !clr && th_s && was_fast_reg && !bias_s && valley_level_w < 8'hf8)
    |=> (valley_level_w == $past(valley_level_w) + 8'h08))
    else $error("valley rate wrong");
endmodule

// ==== pvt_afe_model.sv ====
`timescale 1ns/10ps
// ****************************
// Front end stand-in
// ****************************
module pvt_afe_model
  import pvt_pkg::*;
(
  input wire logic [7:0] peak_level, // Peak code
  input wire logic [7:0] valley_level, // Valley code
  input wire logic [7:0] sig_lvl, // Filtered signal level
  output logic peak_cmp_in, // Signal above peak
  output logic valley_cmp_in, // Signal below valley
  output logic [1:0] adc_code_in, // Coarse code
  output logic filter_cmp_in // Filter as logic level
);
  // Comparators against the counter codes
  assign peak_cmp_in = sig_lvl > peak_level;
  assign valley_cmp_in = sig_lvl < valley_level;
  // Top bits as converter code
  assign adc_code_in = sig_lvl[7:6];
  assign filter_cmp_in = sig_lvl[7];
endmodule

// ==== peak_valley_test_modes_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ****************************
// Bench top
// ****************************
module peak_valley_test_modes_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic test_en = 1'b0;
  logic mode_sel_hi = 1'b0;
  logic mode_sel_lo = 1'b0;
  logic bandwidth_select = 1'b0;
  logic tracking_hold_ctrl = 1'b0;
  logic bias_level_in = 1'b0;
  logic [7:0] sig_lvl = 8'h80; // Signal seen by the model
  wire peak_cmp_in, valley_cmp_in, filter_cmp_in;
  wire [1:0] adc_code_in;
  logic level_out_msb, level_out_lsb, sig_out, filter_wide, adc_enable, upper_is_analog;
  logic [7:0] peak_level, valley_level, dp, dv, p0, v0;
  logic [1:0] test_cfg;
  logic from_fast = 1'b0; // Last tracking mode before test was fast
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  pvt_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .test_en(test_en),
    .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo),
    .bandwidth_select(bandwidth_select), .tracking_hold_ctrl(tracking_hold_ctrl),
    .bias_level_in(bias_level_in), .peak_cmp_in(peak_cmp_in),
    .valley_cmp_in(valley_cmp_in), .adc_code_in(adc_code_in),
    .filter_cmp_in(filter_cmp_in), .level_out_msb(level_out_msb),
    .level_out_lsb(level_out_lsb), .sig_out(sig_out), .peak_level(peak_level),
    .valley_level(valley_level), .filter_wide(filter_wide), .adc_enable(adc_enable),
    .upper_is_analog(upper_is_analog), .test_cfg(test_cfg));
  pvt_afe_model afe (.peak_level(peak_level), .valley_level(valley_level),
    .sig_lvl(sig_lvl), .peak_cmp_in(peak_cmp_in), .valley_cmp_in(valley_cmp_in),
    .adc_code_in(adc_code_in), .filter_cmp_in(filter_cmp_in));
  // ****************************
  // Clock and watchdog
  // ****************************
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out;
    end
  end
  // Verdict and end of run
  task automatic close_out;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Wait edges, then drive just after
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Track in a normal mode, then enter a test configuration
  task automatic enter(input logic [1:0] prev, input logic [1:0] cfg);
    test_en = 1'b0;
    from_fast = (prev == 2'h1);
    {mode_sel_hi, mode_sel_lo} = prev;
    step(6);
    test_en = 1'b1;
    {mode_sel_hi, mode_sel_lo} = cfg;
    step(5);
    `CHK(test_cfg, cfg)
  endtask
  // ****************************
  // Scenarios
  // ****************************
  // Config 0: reset, then count for 40 clocks
  task automatic run0(input logic bias, input logic th);
    bias_level_in = bias;
    tracking_hold_ctrl = th;
    bandwidth_select = 1'b1;
    step(5);
    `CHK(peak_level, 8'h80)
    `CHK(valley_level, 8'h80)
    bandwidth_select = 1'b0;
    step(4);
    p0 = peak_level;
    v0 = valley_level;
    step(40);
    dp = th ? peak_level - p0 : p0 - peak_level;
    dv = th ? valley_level - v0 : v0 - valley_level;
    `CHK(level_out_msb, peak_level[7])
    `CHK(level_out_lsb, valley_level[7])
    `CHK(dp != 8'h00 && dv != 8'h00, 1'b1)
    `CHK(sig_out, th ? bias : (bias ^ from_fast))
  endtask
  // Config 0 rates entered from fast tracking
  task automatic t_from_fast;
    enter(2'h1, 2'h0);
    run0(1'b0, 1'b1);
    `CHK(dp <= 8'h50 && dv > 8'h50, 1'b1)
    run0(1'b1, 1'b1);
    `CHK(dp > 8'h50 && dv <= 8'h50, 1'b1)
  endtask
  // Config 0 rates entered from slow tracking, and saturation
  task automatic t_from_slow;
    enter(2'h3, 2'h0);
    run0(1'b0, 1'b1);
    `CHK(dp == 8'h01 && dv == 8'h01, 1'b1)
    run0(1'b1, 1'b1);
    `CHK(dp > 8'h50 && dv > 8'h50, 1'b1)
    `CHK(peak_level, 8'hff)
    run0(1'b1, 1'b0);
    `CHK(valley_level, 8'h00)
  endtask
  // Config 1: cutoff follows pin, peak counter and converter off
  task automatic t_cfg1;
    enter(2'h3, 2'h1);
    for (int b = 0; b < 2; b++) begin
      bandwidth_select = b[0];
      sig_lvl = b[0] ? 8'hc0 : 8'h30;
      p0 = peak_level;
      step(10);
      `CHK(filter_wide, b[0])
      `CHK(upper_is_analog, 1'b1)
      `CHK(level_out_msb, b[0])
      `CHK(adc_enable, 1'b0)
      `CHK(peak_level, p0)
    end
  endtask
  // Config 2: frozen peak level, comparators crossed to the pins
  task automatic t_cfg2;
    enter(2'h3, 2'h2);
    p0 = peak_level;
    for (int i = 0; i < 2; i++) begin
      sig_lvl = i ? 8'hf8 : 8'h08;
      step(6);
      `CHK(level_out_lsb, peak_cmp_in)
      `CHK(level_out_msb, valley_cmp_in)
      `CHK(peak_level, p0)
    end
  endtask
  // Config 3: separate disables, fixed cutoff, code out
  task automatic t_cfg3;
    enter(2'h3, 2'h3);
    sig_lvl = 8'hf0;
    bandwidth_select = 1'b0;
    tracking_hold_ctrl = 1'b1;
    step(4);
    p0 = peak_level;
    v0 = valley_level;
    step(10);
    `CHK(peak_level != p0 && valley_level == v0, 1'b1)
    bandwidth_select = 1'b1;
    tracking_hold_ctrl = 1'b0;
    step(4);
    p0 = peak_level;
    v0 = valley_level;
    step(50);
    `CHK(peak_level == p0 && valley_level != v0, 1'b1)
    `CHK(filter_wide, 1'b0)
    for (int i = 0; i < 2; i++) begin
      sig_lvl = i ? 8'hc0 : 8'h40;
      step(6);
      `CHK({level_out_msb, level_out_lsb}, sig_lvl[7:6])
    end
  endtask
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    step(3);
    `CHK(peak_level, 8'h80)
    `CHK(test_cfg, 2'h0)
    rst_n = 1'b1;
    step(2);
    t_from_fast;
    t_from_slow;
    t_cfg1;
    t_cfg2;
    t_cfg3;
    close_out;
  end
endmodule
